// ==== rtl/io_base_and_buffer_map.sv ====
// I/O base decode, identity bytes and buffer SRAM mapping
`timescale 1ns/1ns
`default_nettype none
module io_base_and_buffer_map (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Configuration bits
    input  wire logic [2:0]  io_base_code,
    input  wire logic        compat_mode,
    input  wire logic        memory_width_sel,
    input  wire logic        enhanced_mode,
    input  wire logic        bus_clock_source_sel,
    input  wire logic        cfg_from_eeprom,
    // Hidden register writes
    input  wire logic        hidden_wr,
    input  wire logic        hidden_cfg_enable_in,
    input  wire logic        base_extension_enable_in,
    input  wire logic        page_in,
    // Pins from outside
    input  wire logic        slot_width_input,
    input  wire logic        sleep_request,
    input  wire logic        bus_clock_pin,
    // Host I/O cycle
    input  wire logic [9:0]  host_io_addr,
    input  wire logic        host_io_rd,
    output logic             io_hit,
    output logic             id_rd_hit,
    output logic [7:0]       id_rd_data,
    // Identity storage fill and write back
    input  wire logic        id_wr,
    input  wire logic [2:0]  id_wr_idx,
    input  wire logic [7:0]  id_wr_data,
    input  wire logic        id_store_start,
    input  wire logic        eeprom_ack,
    output logic             eeprom_sel,
    output logic [2:0]       eeprom_idx,
    output logic [7:0]       eeprom_wdata,
    output logic             eeprom_busy,
    output logic             skip_cfg_load,
    // Host memory cycle
    input  wire logic [15:0] host_mem_addr,
    input  wire logic        host_mem_req,
    input  wire logic        host_word_req,
    // Buffer SRAM side
    output logic [15:0]      buf_addr,
    output logic             buf_addr_bit15,
    output logic             buf_addr_bit14,
    output logic             buf_addr_bit13,
    output logic             ram_select_low_lane_n,
    output logic             ram_select_high_lane_n,
    output logic             host_word_ok,
    output logic             local_word_ok,
    output logic [1:0]       buffer_size,
    // Status
    output logic             slot_width_detect,
    output logic             hidden_cfg_enable,
    output logic             base_extension_enable,
    output logic             page,
    output logic             low_power,
    output logic             dma_clk_tick
);
    typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT} store_e;

    function automatic logic [1:0] size_of(input logic w, input logic c);
        size_of = {c, w};
    endfunction

    logic [1:0] slot_sync_q;
    logic [1:0] sleep_sync_q;
    logic [1:0] bclk_sync_q;
    logic       bclk_prev_q;
    logic       rst_seen_q;
    logic       detect_q;
    logic       hid_en_q, iobe_q, page_q;
    logic [7:0] id_mem [0:7];
    store_e     st_q;
    logic [2:0] idx_q;
    logic [7:0] wdata_q;
    logic [9:0] io_base;
    logic       base_valid;

    base_decode u_dec (
        .io_base_code          (io_base_code),
        .hidden_cfg_enable     (hid_en_q),
        .base_extension_enable (iobe_q),
        .page                  (page_q),
        .io_base               (io_base),
        .base_valid            (base_valid)
    );

    // Pins pass two flops first
    always_ff @(posedge clk) begin
        slot_sync_q  <= {slot_sync_q[0], slot_width_input};
        sleep_sync_q <= {sleep_sync_q[0], sleep_request};
        bclk_sync_q  <= {bclk_sync_q[0], bus_clock_pin};
    end

    // Detect is caught on the first clock after reset release, not under reset
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rst_seen_q <= 1'b1;
            detect_q   <= iobase_pkg::RST_DETECT;
        end else begin
            rst_seen_q <= 1'b0;
            if (rst_seen_q)
                detect_q <= slot_sync_q[1];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            hid_en_q <= iobase_pkg::RST_HIDDEN;
            iobe_q   <= iobase_pkg::RST_HIDDEN;
            page_q   <= iobase_pkg::RST_HIDDEN;
        end else if (hidden_wr) begin
            hid_en_q <= hidden_cfg_enable_in;
            iobe_q   <= base_extension_enable_in;
            page_q   <= page_in;
        end
    end

    // I/O decode; base is 32-byte aligned
    wire [9:0] io_off   = host_io_addr - io_base;
    wire       in_win   = (io_off[9:5] == 5'h00) && base_valid;
    wire       id_range = (io_off[4:0] >= iobase_pkg::ID_FIRST)
                          && (io_off[4:0] <= iobase_pkg::ID_LAST);
    // Identity reads are refused while the write-back walks the storage
    wire       eeprom_idle = (st_q == ST_IDLE);
    wire       id_sel   = in_win && id_range && compat_mode && eeprom_idle;
    assign io_hit    = in_win;
    assign id_rd_hit = id_sel && host_io_rd;

    always_ff @(posedge clk) begin
        if (!rstn)
            id_rd_data <= 8'h00;
        else if (id_sel && host_io_rd)
            id_rd_data <= id_mem[io_off[2:0]];
    end

    // Identity storage, filled from EEPROM at reset by the loader
    always_ff @(posedge clk) begin
        if (id_wr)
            id_mem[id_wr_idx] <= id_wr_data;
    end
    assign skip_cfg_load = ~cfg_from_eeprom;

    // Write-back sequencer walks all eight bytes
    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_q    <= ST_IDLE;
            idx_q   <= 3'h0;
            wdata_q <= 8'h00;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (id_store_start && enhanced_mode) begin
                        st_q  <= ST_SEND;
                        idx_q <= 3'h0;
                    end
                end
                ST_SEND: begin
                    wdata_q <= id_mem[idx_q];
                    st_q    <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (eeprom_ack) begin
                        if (idx_q == iobase_pkg::ID_DEPTH) begin
                            st_q <= ST_IDLE;
                        end else begin
                            idx_q <= idx_q + 3'h1;
                            st_q  <= ST_SEND;
                        end
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end
    assign eeprom_sel   = (st_q == ST_WAIT);
    assign eeprom_busy  = ~eeprom_idle;
    assign eeprom_idx   = idx_q;
    assign eeprom_wdata = wdata_q;

    // Buffer mapping; host cycles go straight to SRAM with no handshake
    wire [1:0]  size_w  = size_of(memory_width_sel, compat_mode);
    wire [15:0] eff_a   = compat_mode ? host_mem_addr
                          : host_mem_addr;
    wire [15:0] mir_a   = (compat_mode && !memory_width_sel) ?
                          (eff_a & iobase_pkg::COMPAT_MASK) : eff_a;
    logic [15:0] addr_q;
    logic        req_q;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            addr_q <= 16'h0000;
            req_q  <= 1'b0;
        end else begin
            req_q <= host_mem_req;
            if (host_mem_req)
                addr_q <= mir_a;
        end
    end
    assign buf_addr = addr_q;

    logic b15, b14, b13;
    always_comb begin
        b15 = 1'b0;
        b14 = 1'b1;
        b13 = addr_q[0];
        case (size_w)
            iobase_pkg::SIZE_8K: begin
                b15 = 1'b0; b14 = 1'b1; b13 = addr_q[0];
            end
            iobase_pkg::SIZE_16K: begin
                b15 = 1'b0; b14 = 1'b1; b13 = addr_q[13];
            end
            iobase_pkg::SIZE_32K: begin
                b15 = addr_q[0]; b14 = addr_q[14]; b13 = addr_q[13];
            end
            default: begin
                b15 = addr_q[15]; b14 = addr_q[14]; b13 = addr_q[13];
            end
        endcase
    end
    assign buf_addr_bit15 = b15;
    assign buf_addr_bit14 = b14;
    assign buf_addr_bit13 = b13;

    // Lane selects: split only on a 16-bit wide memory
    logic word_q;
    always_ff @(posedge clk) begin
        if (!rstn)
            word_q <= 1'b0;
        else if (host_mem_req)
            word_q <= host_word_req && host_word_ok;
    end
    wire split = memory_width_sel;
    assign ram_select_low_lane_n  = ~(req_q && (!split || word_q || !addr_q[0]));
    assign ram_select_high_lane_n = ~(req_q && split && (word_q || addr_q[0]));

    assign local_word_ok = memory_width_sel;
    assign host_word_ok  = memory_width_sel & detect_q;
    assign buffer_size   = size_w;

    // Bus clock only counts when selected; board grounds it otherwise
    // No reset: a pin already high at reset must not read as a fresh edge
    always_ff @(posedge clk) begin
        bclk_prev_q <= bclk_sync_q[1];
    end
    assign dma_clk_tick = bus_clock_source_sel & bclk_sync_q[1] & ~bclk_prev_q;

    assign low_power             = sleep_sync_q[1];
    assign slot_width_detect     = detect_q;
    assign hidden_cfg_enable     = hid_en_q;
    assign base_extension_enable = iobe_q;
    assign page                  = page_q;

    a_hidden_reset: assert property (@(posedge clk) !rstn |=> !hid_en_q && !iobe_q && !page_q)
        else $error("hidden bits not cleared");
    a_detect_hold: assert property (@(posedge clk) disable iff (!rstn)
        !rst_seen_q |=> $stable(detect_q)) else $error("detect changed");
    a_bad_code: assert property (@(posedge clk)
        (io_base_code == iobase_pkg::CODE_BAD && !(hid_en_q && iobe_q && page_q)) |-> !io_hit)
        else $error("bad code hit");
    a_host_word: assert property (@(posedge clk) host_word_ok |-> memory_width_sel && detect_q)
        else $error("host word wrong");
    a_size_8k: assert property (@(posedge clk) size_w == iobase_pkg::SIZE_8K |->
        !buf_addr_bit15 && buf_addr_bit14 && buf_addr_bit13 == addr_q[0])
        else $error("8k map wrong");
    a_lane_narrow: assert property (@(posedge clk) !memory_width_sel |-> ram_select_high_lane_n)
        else $error("high lane used");
    a_store_walk: assert property (@(posedge clk) disable iff (!rstn)
        st_q == ST_IDLE && id_store_start && !enhanced_mode |=> st_q == ST_IDLE)
        else $error("store without enhanced");
    a_eeprom_sel: assert property (@(posedge clk) disable iff (!rstn)
        st_q == ST_SEND |=> eeprom_sel) else $error("eeprom select late");
endmodule // io_base_and_buffer_map
`default_nettype wire

// ==== rtl/iobase_pkg.sv ====
// Constants for the I/O base decoder and buffer map
package iobase_pkg;
    localparam logic [9:0] BASE_300 = 10'h300;
    localparam logic [9:0] BASE_240 = 10'h240;
    localparam logic [9:0] BASE_280 = 10'h280;
    localparam logic [9:0] BASE_2C0 = 10'h2c0;
    localparam logic [9:0] BASE_320 = 10'h320;
    localparam logic [9:0] BASE_340 = 10'h340;
    localparam logic [9:0] BASE_360 = 10'h360;
    localparam logic [9:0] BASE_380 = 10'h380;
    localparam logic [9:0] BASE_3A0 = 10'h3a0;
    localparam logic [9:0] BASE_3C0 = 10'h3c0;
    localparam logic [9:0] BASE_3E0 = 10'h3e0;
    localparam logic [9:0] BASE_200 = 10'h200;
    localparam logic [9:0] BASE_220 = 10'h220;
    localparam logic [9:0] BASE_2A0 = 10'h2a0;
    localparam logic [9:0] BASE_2E0 = 10'h2e0;
    localparam logic [2:0] CODE_BAD = 3'h1;
    localparam logic [4:0] IO_WINDOW_BITS = 5'h05;
    localparam logic [4:0] ID_FIRST = 5'h08;
    localparam logic [4:0] ID_LAST = 5'h0f;
    localparam logic [2:0] ID_DEPTH = 3'h7;
    localparam logic [15:0] COMPAT_MASK = 16'h3fff;
    localparam logic [1:0] SIZE_8K = 2'h0;
    localparam logic [1:0] SIZE_16K = 2'h1;
    localparam logic [1:0] SIZE_32K = 2'h2;
    localparam logic [1:0] SIZE_64K = 2'h3;
    localparam logic RST_HIDDEN = 1'b0;
    localparam logic RST_DETECT = 1'b0;
endpackage

// ==== rtl/base_decode.sv ====
// Host I/O base lookup from six configuration bits
`timescale 1ns/1ns
`default_nettype none
module base_decode (
    // Configuration
    input  wire logic [2:0] io_base_code,
    input  wire logic       hidden_cfg_enable,
    input  wire logic       base_extension_enable,
    input  wire logic       page,
    // Result
    output logic      [9:0] io_base,
    output logic            base_valid
);
    wire use_page = hidden_cfg_enable & base_extension_enable & page;
    always_comb begin
        base_valid = 1'b1;
        io_base    = iobase_pkg::BASE_300;
        if (use_page) begin
            case (io_base_code)
                3'h0: io_base = iobase_pkg::BASE_380;
                3'h1: io_base = iobase_pkg::BASE_3A0;
                3'h2: io_base = iobase_pkg::BASE_3C0;
                3'h3: io_base = iobase_pkg::BASE_3E0;
                3'h4: io_base = iobase_pkg::BASE_200;
                3'h5: io_base = iobase_pkg::BASE_220;
                3'h6: io_base = iobase_pkg::BASE_2A0;
                default: io_base = iobase_pkg::BASE_2E0;
            endcase
        end else begin
            case (io_base_code)
                3'h0: io_base = iobase_pkg::BASE_300;
                3'h2: io_base = iobase_pkg::BASE_240;
                3'h3: io_base = iobase_pkg::BASE_280;
                3'h4: io_base = iobase_pkg::BASE_2C0;
                3'h5: io_base = iobase_pkg::BASE_320;
                3'h6: io_base = iobase_pkg::BASE_340;
                3'h7: io_base = iobase_pkg::BASE_360;
                default: base_valid = 1'b0;
            endcase
        end
    end
endmodule // base_decode
`default_nettype wire

// ==== verification/eeprom_store_model.sv ====
// EEPROM far-side model that accepts identity bytes written back by the block
`timescale 1ns/1ns
`default_nettype none
module eeprom_store_model (
    // Clock and pacing
    input  wire logic       clk,
    input  wire logic [3:0] ack_delay,
    // Chip select and data from the block
    input  wire logic       eeprom_sel,
    input  wire logic [2:0] eeprom_idx,
    input  wire logic [7:0] eeprom_wdata,
    // Byte accepted
    output logic            eeprom_ack
);
    logic [7:0] mem [8];
    logic [3:0] wait_q = 4'h0;
    initial eeprom_ack = 1'b0;
    // Idle cycle after each ack keeps one byte from being taken twice
    always @(posedge clk) begin
        eeprom_ack <= 1'b0;
        if (eeprom_sel === 1'b1 && eeprom_ack === 1'b0) begin
            wait_q <= wait_q + 4'h1;
            // Slow answers make the block hold its byte while waiting
            if (wait_q >= ack_delay) begin
                mem[eeprom_idx] <= eeprom_wdata;
                eeprom_ack <= 1'b1;
                wait_q <= 4'h0;
            end
        end
    end
endmodule // eeprom_store_model
`default_nettype wire

// ==== verification/io_base_and_buffer_map_test.sv ====
// Self-checking bench for the I/O base decoder and buffer map
`timescale 1ns/1ns
`default_nettype none
module io_base_and_buffer_map_test;
    typedef struct packed {
        logic [2:0] code;
        logic       ok;
        logic [9:0] low_base;
        logic [9:0] high_base;
    } row_s;
    // Per code: legacy base, then the upper page base
    row_s rows [8] = '{
        '{3'h0, 1'b1, 10'h300, 10'h380}, '{3'h1, 1'b0, 10'h000, 10'h3a0},
        '{3'h2, 1'b1, 10'h240, 10'h3c0}, '{3'h3, 1'b1, 10'h280, 10'h3e0},
        '{3'h4, 1'b1, 10'h2c0, 10'h200}, '{3'h5, 1'b1, 10'h320, 10'h220},
        '{3'h6, 1'b1, 10'h340, 10'h2a0}, '{3'h7, 1'b1, 10'h360, 10'h2e0}};
    logic clk, rstn, compat_mode, memory_width_sel, enhanced_mode, bus_clock_source_sel;
    logic cfg_from_eeprom, hidden_wr, hidden_cfg_enable_in, base_extension_enable_in, page_in;
    logic slot_width_input, sleep_request, bus_clock_pin, host_io_rd, io_hit, id_rd_hit;
    logic id_wr, id_store_start, eeprom_ack, eeprom_sel, eeprom_busy, skip_cfg_load;
    logic host_mem_req, host_word_req, buf_addr_bit15, buf_addr_bit14, buf_addr_bit13;
    logic ram_select_low_lane_n, ram_select_high_lane_n, host_word_ok, local_word_ok;
    logic slot_width_detect, hidden_cfg_enable, base_extension_enable, page, low_power;
    logic dma_clk_tick, det, ok;
    logic [2:0]  io_base_code, id_wr_idx, eeprom_idx;
    logic [9:0]  host_io_addr, eb;
    logic [7:0]  id_rd_data, id_wr_data, eeprom_wdata;
    logic [15:0] host_mem_addr, buf_addr, ea;
    logic [1:0]  buffer_size;
    logic [3:0]  ack_delay;
    int          errors = 0;
    int          n_tests = 0;
    int          ticks = 0;

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    io_base_and_buffer_map u_dut (.*);
    eeprom_store_model u_model (.clk, .ack_delay, .eeprom_sel, .eeprom_idx, .eeprom_wdata,
                                .eeprom_ack);

    always @(posedge clk) if (dma_clk_tick === 1'b1) ticks++;

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("Checks %0d, errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic do_reset(input logic s);
        ticks = 0;
        @(posedge clk);
        rstn <= 1'b0;
        slot_width_input <= s;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (5) @(posedge clk);
        #2;
        check("detect", 16'(s), 16'(slot_width_detect));
        check("hidden_rst", 16'h0,
              16'({hidden_cfg_enable, base_extension_enable, page}));
        @(posedge clk);
        slot_width_input <= ~s;
        repeat (5) @(posedge clk);
        #2;
        check("detect_hold", 16'(s), 16'(slot_width_detect));
        check("tick_rst", 16'h0, 16'(ticks));
        det = s;
    endtask

    task automatic set_hidden(input logic e, input logic x, input logic p);
        @(posedge clk);
        hidden_cfg_enable_in <= e;
        base_extension_enable_in <= x;
        page_in <= p;
        hidden_wr <= 1'b1;
        @(posedge clk);
        hidden_wr <= 1'b0;
        #2;
        check("hidden", 16'({e, x, p}),
              16'({hidden_cfg_enable, base_extension_enable, page}));
    endtask

    task automatic fill_read(input logic [7:0] seed);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            id_wr <= 1'b1;
            id_wr_idx <= 3'(i);
            id_wr_data <= seed ^ 8'(i * 17);
        end
        @(posedge clk);
        id_wr <= 1'b0;
        for (int i = 6; i < 17; i++) begin
            @(posedge clk);
            compat_mode <= (i < 16);
            host_io_rd <= (i != 9);
            host_io_addr <= 10'h380 + 10'(i & 15);
            #2;
            check("id_hit", 16'(i > 7 && i < 16 && i != 9), 16'(id_rd_hit));
            @(posedge clk);
            #2;
            // A cycle without read strobe leaves the byte of offset 08h standing
            if (i > 7 && i < 16)
                check("id_data", 16'(seed ^ 8'((i - 8 - (i == 9)) * 17)),
                      16'(id_rd_data));
        end
    endtask

    task automatic store(input logic en, input logic [3:0] dly, input logic [7:0] seed);
        int n;
        @(posedge clk);
        enhanced_mode <= en;
        ack_delay <= dly;
        id_store_start <= 1'b1;
        compat_mode <= 1'b1;
        host_io_addr <= 10'h388;
        @(posedge clk);
        id_store_start <= 1'b0;
        #2;
        check("busy", 16'(en), 16'(eeprom_busy));
        check("id_busy", 16'(!en), 16'(id_rd_hit));
        n = 0;
        while (eeprom_busy === 1'b1 && n < 300) begin
            @(posedge clk);
            #2;
            n++;
        end
        check("busy_end", 16'h0, 16'(eeprom_busy));
        for (int i = 0; i < 8; i++)
            if (en) check("stored", 16'(seed ^ 8'(i * 17)),
                          16'(u_model.mem[i]));
    endtask

    task automatic mem_case(input logic [1:0] sz, input logic [15:0] a, input logic w);
        logic [2:0] hb;
        logic [1:0] cs;
        @(posedge clk);
        compat_mode <= sz[1];
        memory_width_sel <= sz[0];
        host_mem_addr <= a;
        host_word_req <= w;
        host_mem_req <= 1'b1;
        @(posedge clk);
        #2;
        ea = (sz == 2'h2) ? (a & 16'h3fff) : a;
        case (sz)
            2'h0: hb = {2'b01, ea[0]};
            2'h1: hb = {2'b01, ea[13]};
            2'h2: hb = {ea[0], ea[14], ea[13]};
            default: hb = ea[15:13];
        endcase
        if (!sz[0]) cs = 2'b10;
        else if (w && det) cs = 2'b00;
        else cs = ea[0] ? 2'b01 : 2'b10;
        check("size", 16'(sz), 16'(buffer_size));
        check("buf_addr", ea, buf_addr);
        check("high_addr", 16'(hb),
              16'({buf_addr_bit15, buf_addr_bit14, buf_addr_bit13}));
        check("lanes", 16'(cs), 16'({ram_select_high_lane_n, ram_select_low_lane_n}));
        check("word_ok", 16'({sz[0] & det, sz[0]}), 16'({host_word_ok, local_word_ok}));
    endtask

    initial begin
        {rstn, compat_mode, memory_width_sel, enhanced_mode, bus_clock_source_sel} = '0;
        {hidden_wr, hidden_cfg_enable_in, base_extension_enable_in, page_in} = '0;
        {slot_width_input, sleep_request, bus_clock_pin, id_wr, id_store_start} = '0;
        {host_mem_req, host_word_req, io_base_code, id_wr_idx, id_wr_data} = '0;
        {host_mem_addr, ack_delay, det, cfg_from_eeprom} = '0;
        host_io_rd = 1'b1;
        host_io_addr = 10'h000;
        do_reset(1'b1);
        for (int m = 0; m < 4; m++) begin
            set_hidden(m != 0, m != 1, m != 2);
            foreach (rows[i]) begin
                eb = (m == 3) ? rows[i].high_base : rows[i].low_base;
                ok = (m == 3) || rows[i].ok;
                for (int k = 0; k < 32; k++) begin
                    @(posedge clk);
                    io_base_code <= rows[i].code;
                    host_io_addr <= 10'(k * 32 + i * 4 + 3);
                    #2;
                    check("io_hit", 16'(ok && eb[9:5] == 5'(k)),
                          16'(io_hit));
                end
            end
        end
        io_base_code <= 3'h0;
        fill_read(8'h3c);
        store(1'b0, 4'h0, 8'h3c);
        store(1'b1, 4'h0, 8'h3c);
        fill_read(8'hc5);
        store(1'b1, 4'h5, 8'hc5);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            cfg_from_eeprom <= i[0];
            sleep_request <= ~i[0];
            repeat (4) @(posedge clk);
            #2;
            check("skip_cfg", 16'(!i[0]), 16'(skip_cfg_load));
            check("low_power", 16'(!i[0]), 16'(low_power));
        end
        for (int s = 0; s < 2; s++) begin
            @(posedge clk);
            bus_clock_source_sel <= s[0];
            #2;
            ticks = 0;
            for (int t = 0; t < 12; t++) begin
                @(posedge clk);
                bus_clock_pin <= s[0] & t[1];
            end
            repeat (5) @(posedge clk);
            #2;
            check("dma_ticks", 16'(s * 3), 16'(ticks));
        end
        for (int r = 0; r < 2; r++) begin
            for (int z = 0; z < 4; z++) begin
                mem_case(2'(z), 16'hc001, 1'b0);
                mem_case(2'(z), 16'h4aa2, 1'b1);
                mem_case(2'(z), 16'h9ffd, 1'b0);
            end
            do_reset(1'b0);
        end
        stop_test();
    end

    initial begin
        #200000;
        errors++;
        $display("CHECK FAILED watchdog expected done seen hang");
        stop_test();
    end
endmodule // io_base_and_buffer_map_test
`default_nettype wire
